// ==== design/exec_pkg.sv ====
// constants and carrier types for the and/branch executor
// assumes one core clock; instruction words come from a fetch unit on that clock
// Notes on behaviour
// - literal mask ANDs immediate into accumulator
// - register mask ANDs accumulator with file register
// - destination bit zero writes accumulator only
// - destination bit one writes file register
// - bank bit zero uses access bank
// - bank bit one uses bank select
// - extended set indexes addresses up to 95
// - branch on carry decoded from upper byte
// - branch only on carry, flags untouched
// - displacement doubled, added as signed value
// - target is address plus two plus 2n
// - taken branch two cycles, second is nop
`default_nettype none
package exec_pkg;
	localparam int PC_W = 21;
	localparam int FA_W = 12;
	localparam logic [7:0] OPC_LIT = 8'h0B;
	localparam logic [5:0] OPC_REG = 6'h05;
	localparam logic [7:0] OPC_BC = 8'hE2;
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;
	localparam logic [7:0] IDX_LIMIT = 8'h5F;
	localparam logic [7:0] ACC_SPLIT = 8'h80;
	localparam logic [3:0] ACC_LO_BANK = 4'h0;
	localparam logic [3:0] ACC_HI_BANK = 4'hF;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [PC_W-1:0] PC_RST = 21'h000000;
	localparam logic [7:0] W_RST = 8'h00;

	typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_t;
	typedef enum logic [1:0] {OP_NONE, OP_LIT, OP_REG, OP_BC} op_t;

	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} flags_t;

	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic [7:0]      w;
		flags_t          flags;
	} load_t;

	typedef struct packed {
		logic [FA_W-1:0] addr;
		logic            rd;
		logic            wr;
		logic [7:0]      wdata;
	} file_req_t;

	typedef struct packed {
		phase_t          phase;
		op_t             op;
		logic            flush;
		logic            taken;
		logic            fetch_req;
		logic            done;
		logic [15:0]     ir;
		logic [PC_W-1:0] pc;
		logic [7:0]      w;
		logic [7:0]      result;
		flags_t          flags;
		file_req_t       file;
	} state_t;
endpackage
`default_nettype wire

// ==== design/and_and_carry_branch_exec.sv ====
// executes literal mask, register mask and branch on carry in four phases
// assumes every input is on core_clk_i; the file memory returns read data
// in the same phase as its read strobe and writes on the edge ending its write strobe
`timescale 1ns/1ps
`default_nettype none
module and_and_carry_branch_exec (
	input  wire logic                     core_clk_i,
	input  wire logic                     nrst_i,
	input  wire logic [15:0]              instr_i,
	input  wire logic                     instr_valid_i,
	input  wire logic [7:0]               file_rdata_i,
	input  wire logic [3:0]               bank_sel_reg_i,
	input  wire logic                     ext_set_en_i,
	input  wire logic [exec_pkg::FA_W-1:0] idx_base_i,
	input  wire logic                     state_load_i,
	input  wire exec_pkg::load_t          load_i,
	output logic                          fetch_req_o,
	output logic [exec_pkg::PC_W-1:0]     pc_o,
	output logic [7:0]                    w_o,
	output exec_pkg::flags_t              flags_o,
	output exec_pkg::file_req_t           file_o,
	output logic                          branch_taken_o,
	output logic                          done_o
);

	////////////////////////////////////////////////////////////////////////
	exec_pkg::state_t s;
	exec_pkg::state_t next_s;
	logic [7:0]       opnd;
	logic [7:0]       fld;

	assign fld = s.ir[7:0];

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		opnd = (s.op == exec_pkg::OP_LIT) ? fld : file_rdata_i;
		case (s.phase)
			exec_pkg::Q1: begin
				// a flushed cycle fetches nothing and decodes nothing
				if (s.flush) begin
					next_s.phase = exec_pkg::Q2;
				end else if (instr_valid_i) begin
					next_s.ir = instr_i;
					next_s.pc = s.pc + exec_pkg::PC_STEP;
					next_s.fetch_req = 1'b0;
					next_s.phase = exec_pkg::Q2;
					if (instr_i[15:8] == exec_pkg::OPC_LIT) begin
						next_s.op = exec_pkg::OP_LIT;
					end else if (instr_i[15:10] == exec_pkg::OPC_REG) begin
						next_s.op = exec_pkg::OP_REG;
					end else if (instr_i[15:8] == exec_pkg::OPC_BC) begin
						next_s.op = exec_pkg::OP_BC;
					end else begin
						next_s.op = exec_pkg::OP_NONE;
					end
				end
			end
			exec_pkg::Q2: begin
				next_s.phase = exec_pkg::Q3;
				if (s.op == exec_pkg::OP_REG) begin
					// address settles in q2 so the memory can answer within q3
					next_s.file.rd = 1'b1;
					if (s.ir[exec_pkg::BANK_BIT]) begin
						next_s.file.addr = {bank_sel_reg_i, fld};
					end else if (ext_set_en_i && fld <= exec_pkg::IDX_LIMIT) begin
						next_s.file.addr = idx_base_i + {4'h0, fld};
					end else if (fld < exec_pkg::ACC_SPLIT) begin
						next_s.file.addr = {exec_pkg::ACC_LO_BANK, fld};
					end else begin
						next_s.file.addr = {exec_pkg::ACC_HI_BANK, fld};
					end
				end
			end
			exec_pkg::Q3: begin
				next_s.phase = exec_pkg::Q4;
				next_s.file.rd = 1'b0;
				next_s.result = s.w & opnd;
				// write data is the result itself, so the write fits in q4
				if (s.op == exec_pkg::OP_REG && s.ir[exec_pkg::DEST_BIT]) begin
					next_s.file.wr = 1'b1;
					next_s.file.wdata = s.w & opnd;
				end
				next_s.taken = (s.op == exec_pkg::OP_BC) && s.flags.c;
			end
			exec_pkg::Q4: begin
				next_s.phase = exec_pkg::Q1;
				next_s.file.wr = 1'b0;
				next_s.done = 1'b1;
				if (s.op == exec_pkg::OP_LIT
					|| (s.op == exec_pkg::OP_REG && !s.ir[exec_pkg::DEST_BIT])) begin
					next_s.w = s.result;
				end
				if (s.op == exec_pkg::OP_LIT || s.op == exec_pkg::OP_REG) begin
					// carry, overflow and digit carry are left alone
					next_s.flags.n = s.result[7];
					next_s.flags.z = (s.result == 8'h00);
				end
				if (s.taken) begin
					// pc already points past this word, so adding 2n gives
					// instruction address plus two plus 2n
					next_s.pc = s.pc + {{(exec_pkg::PC_W-9){fld[7]}}, fld, 1'b0};
				end
				next_s.flush = s.taken;
				next_s.fetch_req = !s.taken;
				next_s.taken = 1'b0;
				next_s.op = exec_pkg::OP_NONE;
			end
			default: begin
				next_s.phase = exec_pkg::Q1;
			end
		endcase
		if (s.phase == exec_pkg::Q4 && s.flush) begin
			next_s.flush = 1'b0;
			next_s.fetch_req = 1'b1;
		end
		// a load overrides the architectural state in any phase
		if (state_load_i) begin
			next_s.pc = load_i.pc;
			next_s.w = load_i.w;
			next_s.flags = load_i.flags;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '0;
			s.phase <= exec_pkg::Q1;
			s.op <= exec_pkg::OP_NONE;
			s.fetch_req <= 1'b1;
			s.pc <= exec_pkg::PC_RST;
			s.w <= exec_pkg::W_RST;
		end else begin
			s <= next_s;
		end
	end

	// outputs are plain register fields, nothing after the flops
	assign fetch_req_o = s.fetch_req;
	assign pc_o = s.pc;
	assign w_o = s.w;
	assign flags_o = s.flags;
	assign file_o = s.file;
	assign branch_taken_o = s.taken;
	assign done_o = s.done;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	logic q3_reg;
	logic q3_lit;
	logic q2_reg;
	assign q3_reg = s.phase == exec_pkg::Q3 && s.op == exec_pkg::OP_REG && !state_load_i;
	assign q3_lit = s.phase == exec_pkg::Q3 && s.op == exec_pkg::OP_LIT && !state_load_i;
	assign q2_reg = s.phase == exec_pkg::Q2 && s.op == exec_pkg::OP_REG;

	lit_w_update_a: assert property (
		q3_lit ##1 !state_load_i |=> w_o == $past(s.w & fld, 2))
		else $error("literal mask result wrong in accumulator");

	reg_to_w_a: assert property (
		q3_reg && !s.ir[exec_pkg::DEST_BIT] ##1 !state_load_i
		|-> !file_o.wr ##1 w_o == $past(s.w & file_rdata_i, 2))
		else $error("register mask to accumulator wrong");

	reg_to_file_a: assert property (
		q3_reg && s.ir[exec_pkg::DEST_BIT] ##1 !state_load_i
		|-> file_o.wr && file_o.wdata == $past(s.w & file_rdata_i) ##1 w_o == $past(w_o))
		else $error("register mask write back wrong");

	bank_addr_a: assert property (
		q2_reg && s.ir[exec_pkg::BANK_BIT]
		|=> file_o.rd && file_o.addr == {$past(bank_sel_reg_i), $past(fld)})
		else $error("banked address wrong");

	access_addr_a: assert property (
		q2_reg && !s.ir[exec_pkg::BANK_BIT] && (!ext_set_en_i || fld > exec_pkg::IDX_LIMIT)
		|=> file_o.addr[7:0] == $past(fld)
			&& file_o.addr[11:8] == ($past(fld[7]) ? exec_pkg::ACC_HI_BANK : exec_pkg::ACC_LO_BANK))
		else $error("access bank address wrong");

	indexed_addr_a: assert property (
		q2_reg && !s.ir[exec_pkg::BANK_BIT] && ext_set_en_i && fld <= exec_pkg::IDX_LIMIT
		|=> file_o.addr == $past(idx_base_i) + {4'h0, $past(fld)})
		else $error("indexed literal offset address wrong");

	branch_target_a: assert property (
		s.phase == exec_pkg::Q4 && s.taken && !state_load_i
		|=> pc_o == $past(s.pc) + {{(exec_pkg::PC_W-9){$past(fld[7])}}, $past(fld), 1'b0})
		else $error("branch target wrong");

	branch_decide_a: assert property (
		s.phase == exec_pkg::Q3 && s.op == exec_pkg::OP_BC && !state_load_i
		|=> branch_taken_o == $past(s.flags.c) && flags_o == $past(flags_o))
		else $error("branch on carry decision wrong");

	taken_nop_a: assert property (
		s.phase == exec_pkg::Q4 && s.taken |=> !fetch_req_o [*4] ##1 fetch_req_o)
		else $error("taken branch did not insert one nop cycle");

	and_flags_a: assert property (
		s.phase == exec_pkg::Q4 && (s.op == exec_pkg::OP_LIT || s.op == exec_pkg::OP_REG)
			&& !state_load_i
		|=> flags_o.n == $past(s.result[7]) && flags_o.z == ($past(s.result) == 8'h00)
			&& flags_o.c == $past(flags_o.c) && flags_o.ov == $past(flags_o.ov)
			&& flags_o.dc == $past(flags_o.dc))
		else $error("and flag update wrong");

	four_phase_a: assert property (
		s.phase == exec_pkg::Q1 && !s.flush && instr_valid_i
		|=> s.phase == exec_pkg::Q2 ##1 s.phase == exec_pkg::Q3 ##1 s.phase == exec_pkg::Q4 ##1 done_o)
		else $error("instruction did not run four phases");

	lit_result_a: assert property (
		q3_lit |=> s.result == $past(s.w & fld))
		else $error("literal mask result wrong");

	bc_decode_a: assert property (
		s.phase == exec_pkg::Q1 && !s.flush && instr_valid_i && instr_i[15:8] == exec_pkg::OPC_BC
		|=> s.op == exec_pkg::OP_BC)
		else $error("branch on carry not decoded");

	reg_decode_a: assert property (
		s.phase == exec_pkg::Q1 && !s.flush && instr_valid_i && instr_i[15:10] == exec_pkg::OPC_REG
		|=> s.op == exec_pkg::OP_REG)
		else $error("register mask not decoded");

	// file port: one read and at most one write per register mask
	rd_strobe_a: assert property (
		file_o.rd |-> s.phase == exec_pkg::Q3 && s.op == exec_pkg::OP_REG ##1 !file_o.rd)
		else $error("file read strobe outside its phase");

	wr_strobe_a: assert property (
		file_o.wr |-> s.phase == exec_pkg::Q4 && s.op == exec_pkg::OP_REG
			&& s.ir[exec_pkg::DEST_BIT] && $stable(file_o.addr))
		else $error("file write strobe without a file destination");

	addr_hold_a: assert property (
		!q2_reg |=> $stable(file_o.addr))
		else $error("file address moved outside a register mask");

	// program counter and branch sequencing
	pc_step_a: assert property (
		s.phase == exec_pkg::Q1 && !s.flush && instr_valid_i && !state_load_i
		|=> pc_o == $past(pc_o) + exec_pkg::PC_STEP)
		else $error("pc did not advance past the fetched word");

	not_taken_a: assert property (
		s.phase == exec_pkg::Q4 && s.op == exec_pkg::OP_BC && !s.taken && !state_load_i
		|=> pc_o == $past(pc_o) && fetch_req_o && !s.flush)
		else $error("branch not taken still moved pc or stalled");

	bc_keeps_a: assert property (
		s.phase == exec_pkg::Q4 && s.op == exec_pkg::OP_BC && !state_load_i
		|=> w_o == $past(w_o) && flags_o == $past(flags_o))
		else $error("branch on carry changed accumulator or flags");

	taken_cause_a: assert property (
		branch_taken_o |-> s.phase == exec_pkg::Q4 && s.op == exec_pkg::OP_BC && $past(s.flags.c))
		else $error("branch taken without carry");

	flush_idle_a: assert property (
		s.flush && s.phase == exec_pkg::Q1
		|=> s.op == exec_pkg::OP_NONE && $stable(s.ir) && !fetch_req_o)
		else $error("nop cycle after a branch decoded a word");

	flush_end_a: assert property (
		s.flush && s.phase == exec_pkg::Q4 |=> !s.flush && fetch_req_o && done_o)
		else $error("nop cycle after a branch did not end");

	other_idle_a: assert property (
		s.phase == exec_pkg::Q4 && s.op == exec_pkg::OP_NONE && !state_load_i
		|=> pc_o == $past(pc_o) && w_o == $past(w_o) && flags_o == $past(flags_o))
		else $error("undecoded word changed architectural state");

	// phase sequencing
	done_pulse_a: assert property (
		done_o |-> s.phase == exec_pkg::Q1 ##1 !done_o)
		else $error("done pulse outside the first phase");

	fetch_q1_a: assert property (
		fetch_req_o |-> s.phase == exec_pkg::Q1 && !s.flush)
		else $error("fetch request outside a free first phase");

	q1_wait_a: assert property (
		s.phase == exec_pkg::Q1 && !s.flush && !instr_valid_i
		|=> s.phase == exec_pkg::Q1 && fetch_req_o)
		else $error("idle first phase did not wait");

	q4_wrap_a: assert property (
		s.phase == exec_pkg::Q4 |=> s.phase == exec_pkg::Q1)
		else $error("fourth phase did not wrap");

	lit_c: cover property (q3_lit ##2 done_o);
	reg_w_c: cover property (q3_reg && !s.ir[exec_pkg::DEST_BIT]);
	reg_f_c: cover property (q3_reg ##1 file_o.wr);
	bc_taken_c: cover property (branch_taken_o ##4 (s.flush && s.phase == exec_pkg::Q4));
	bc_not_c: cover property (s.phase == exec_pkg::Q4 && s.op == exec_pkg::OP_BC && !s.taken);

endmodule
`default_nettype wire

// ==== verif/file_mem_model.sv ====
// file register memory for the executor's file port
// assumes rd and wr strobes as the executor drives them, one clock
`timescale 1ns/1ps
`default_nettype none
module file_mem_model (
	input  wire logic                core_clk_i,
	input  wire exec_pkg::file_req_t file_i,
	output logic [7:0]               rdata_o
);
	logic [7:0] mem [0:4095];
	logic [7:0] last = 8'h00;
	// outside a read the bus shows the inverse, so stale data never matches
	assign rdata_o = file_i.rd ? mem[file_i.addr] : ~last;
	always @(posedge core_clk_i) begin
		if (file_i.rd)
			last <= mem[file_i.addr];
		if (file_i.wr)
			mem[file_i.addr] <= file_i.wdata;
	end
endmodule
`default_nettype wire

// ==== verif/tb_and_and_carry_branch_exec.sv ====
// random and corner instruction runs against the executor
// assumes the file memory model answers in the read cycle
`timescale 1ns/1ps
`default_nettype none
module tb_and_and_carry_branch_exec;
	logic                core_clk_i, nrst_i, vld, ext, ld, fetch, taken, done, tk;
	logic [15:0]         instr, wd;
	logic [7:0]          rdata, w, r, cl, ew;
	logic [3:0]          bank;
	logic [11:0]         idx, ad;
	logic [20:0]         pc, epc;
	exec_pkg::load_t     load;
	exec_pkg::flags_t    flags, ef;
	exec_pkg::file_req_t file;
	int                  fail_count, total_checks, i, n, k;
	logic [7:0]          cf [6] = '{8'h5F, 8'h60, 8'h7F, 8'h80, 8'h00, 8'hFF};
	and_and_carry_branch_exec i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .instr_i(instr),
		.instr_valid_i(vld), .file_rdata_i(rdata), .bank_sel_reg_i(bank), .ext_set_en_i(ext),
		.idx_base_i(idx), .state_load_i(ld), .load_i(load), .fetch_req_o(fetch), .pc_o(pc),
		.w_o(w), .flags_o(flags), .file_o(file), .branch_taken_o(taken), .done_o(done));
	file_mem_model i_mem (.core_clk_i(core_clk_i), .file_i(file), .rdata_o(rdata));
	////////////////////////////////////////////////////////////////
	function automatic logic [11:0] fa(logic [7:0] f, logic a, logic e, logic [3:0] b, logic [11:0] x);
		if (a)
			return {b, f};
		if (e && f <= 8'h5F)
			return x + 12'(f);
		return {f[7] ? 4'hF : 4'h0, f};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (e !== s) begin
			fail_count++;
			$display("CHECK FAILED %s exp %0h got %0h", nm, e, s);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		#(25 * 4000);
		fail_count++;
		results();
	end
	initial begin
		{nrst_i, vld, ext, ld} = 4'h0;
		instr = 16'h0000;
		bank = 4'h0;
		idx = 12'h000;
		load = '0;
		void'($urandom(57142));
		for (i = 0; i < 4096; i++)
			i_mem.mem[i] = 8'($urandom);
		repeat (8) @(posedge core_clk_i);
		@(negedge core_clk_i);
		nrst_i = 1'b1;
		for (i = 0; i < 80; i++) begin
			k = $urandom % 4;
			wd = 16'($urandom);
			load.pc = 21'($urandom) & ~21'h1;
			load.w = 8'($urandom);
			load.flags = 5'($urandom);
			bank = 4'($urandom);
			ext = 1'($urandom);
			idx = 12'($urandom);
			// awkward cases first: index limit, access split, widest displacements
			if (i < 6) begin
				k = 1;
				ext = 1'b1;
				wd[8] = 1'b0;
				wd[7:0] = cf[i];
			end else if (i < 10) begin
				k = 2;
				wd[7:0] = i[0] ? 8'h80 : 8'h7F;
				load.flags.c = i[1];
			end
			// upper byte FF decodes to nothing: only pc may move
			instr = k == 0 ? {exec_pkg::OPC_LIT, wd[7:0]} : k == 1 ? {exec_pkg::OPC_REG, wd[9:0]}
				: k == 2 ? {exec_pkg::OPC_BC, wd[7:0]} : {8'hFF, wd[7:0]};
			ad = fa(wd[7:0], wd[8], ext, bank, idx);
			cl = i_mem.mem[ad];
			r = load.w & (k == 0 ? wd[7:0] : cl);
			ew = load.w;
			ef = load.flags;
			epc = load.pc + 21'h2;
			if (k < 2) begin
				ef.n = r[7];
				ef.z = r == 8'h00;
				if (k == 0 || !wd[9])
					ew = r;
				else
					cl = r;
			end else if (k == 2 && load.flags.c)
				epc = epc + {{12{wd[7]}}, wd[7:0], 1'b0};
			n = 0;
			while (fetch !== 1'b1 && n < 20) begin
				@(negedge core_clk_i);
				n++;
			end
			ld = 1'b1;
			@(negedge core_clk_i);
			ld = 1'b0;
			vld = 1'b1;
			tk = 1'b0;
			@(negedge core_clk_i);
			vld = 1'b0;
			n = 1;
			while (done !== 1'b1 && n < 20) begin
				@(negedge core_clk_i);
				n++;
				if (taken === 1'b1)
					tk = 1'b1;
			end
			chk("done cycle", 4, n);
			chk("taken", k == 2 && load.flags.c, tk);
			n = 0;
			while (fetch !== 1'b1 && n < 20) begin
				@(negedge core_clk_i);
				n++;
			end
			chk("nop cycles", tk ? 4 : 0, n);
			chk("w", ew, w);
			chk("flags", ef, flags);
			chk("pc", epc, pc);
			chk("cell", cl, i_mem.mem[ad]);
			// mid-run reset: state must be back at reset values one clock later, then the run goes on
			if (i == 40) begin
				nrst_i = 1'b0;
				@(negedge core_clk_i);
				chk("reset pc", 0, pc);
				chk("reset w", 0, w);
				chk("reset flags", 0, flags);
				chk("reset fetch", 1, fetch);
				chk("reset file", 0, file);
				chk("reset pulses", 0, {done, taken});
				nrst_i = 1'b1;
			end
		end
		results();
	end
endmodule
`default_nettype wire
